// >>> inc/sfepoc_pkg.sv
package sfepoc_pkg;
  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_SECTOR_ERASE = 8'hD8;
  localparam logic [7:0] OP_ARRAY_ERASE = 8'hC7;
  localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WAKE_SIG = 8'hAB;
  localparam logic [7:0] OP_CLEAR_FAIL = 8'h30;
  localparam logic [7:0] OP_OTP_WRITE = 8'h42;
  localparam logic [7:0] OP_OTP_READ = 8'h4B;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  // ----------------------------------------------------------------
  // frame lengths in serial clock rising edges
  // ----------------------------------------------------------------
  localparam logic [15:0] BITS_OPCODE = 16'h0008;
  localparam logic [15:0] BITS_ADDR = 16'h0020;
  localparam logic [15:0] BITS_OTP_WRITE = 16'h0028;
  localparam logic [15:0] BITS_OTP_DATA = 16'h0028;
  localparam logic [15:0] BITS_SIG_START = 16'h0020;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int SECTOR_ERASE_TIME_US = 500;
  localparam int ARRAY_ERASE_TIME_US = 4000;
  localparam int OTP_WRITE_TIME_US = 100;
  localparam int SLEEP_ENTRY_DELAY_NS = 3000;
  localparam int WAKE_DELAY_NS = 3000;
  localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_TIME_US * CLK_MHZ;
  localparam int ARRAY_ERASE_CYC = ARRAY_ERASE_TIME_US * CLK_MHZ;
  localparam int OTP_WRITE_CYC = OTP_WRITE_TIME_US * CLK_MHZ;
  localparam int SLEEP_ENTRY_CYC =
    (SLEEP_ENTRY_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_CYC = (WAKE_DELAY_NS * CLK_MHZ + 999) / 1000;
  // ----------------------------------------------------------------
  // array and otp layout
  // ----------------------------------------------------------------
  localparam int SECTORS = 128;
  localparam int OTP_DEPTH = 532;
  localparam int OTP_LOCK_BASE = 16;
  localparam int OTP_LOCK_BYTES = 8;
  localparam logic [2:0] PIN_SYNC_RST = 3'h1;
  localparam logic [7:0] OTP_ERASED = 8'hFF;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_BUSY = 5'h02,
    ST_ENTER = 5'h04,
    ST_DEEP = 5'h08,
    ST_WAKE = 5'h10
  } sfepoc_state_t;
endpackage : sfepoc_pkg

// >>> rtl/sfepoc_otp_mem.sv
module sfepoc_otp_mem #(
  parameter int DEPTH = sfepoc_pkg::OTP_DEPTH,
  parameter int AW = 10
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data_q,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data
);
  logic [7:0] mem_q [DEPTH];

  // contents are held in flops here; reset stands in for a blank part
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= sfepoc_pkg::OTP_ERASED;
      end
    end else if (wr_en && (int'(wr_addr) < DEPTH)) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data_q <= sfepoc_pkg::OTP_ERASED;
    end else if (int'(rd_addr) < DEPTH) begin
      rd_data_q <= mem_q[rd_addr];
    end else begin
      rd_data_q <= sfepoc_pkg::OTP_ERASED;
    end
  end
endmodule : sfepoc_otp_mem

// >>> rtl/sfepoc_top.sv
module sfepoc_top #(
  parameter logic [7:0] SIGNATURE = 8'h5A, // arbitrary value
  parameter int SECTOR_ERASE_CYC = sfepoc_pkg::SECTOR_ERASE_CYC,
  parameter int ARRAY_ERASE_CYC = sfepoc_pkg::ARRAY_ERASE_CYC,
  parameter int OTP_WRITE_CYC = sfepoc_pkg::OTP_WRITE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  output logic so_q,
  output logic so_oe_q,
  input wire logic [2:0] block_protect_field,
  input wire logic erase_fail_set,
  input wire logic program_fail_set,
  output logic write_enable_latch_q,
  output logic write_in_progress_bit_q,
  output logic erase_fail_flag_q,
  output logic program_fail_flag_q,
  output logic deep_sleep_q,
  output logic otp_space_q,
  output logic erase_go_q,
  output logic erase_all_q,
  output logic [6:0] erase_sector_q
);
  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [2:0] pin_s1_q, pin_s2_q, pin_s3_q;
  logic cs_low, cs_rise, sck_rise, sck_fall, si_s;

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1_q <= sfepoc_pkg::PIN_SYNC_RST;
      pin_s2_q <= sfepoc_pkg::PIN_SYNC_RST;
      pin_s3_q <= sfepoc_pkg::PIN_SYNC_RST;
    end else begin
      pin_s1_q <= {si, sck, cs_n};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  assign cs_low = !pin_s2_q[0];
  assign cs_rise = pin_s2_q[0] && !pin_s3_q[0];
  assign sck_rise = cs_low && pin_s2_q[1] && !pin_s3_q[1];
  assign sck_fall = cs_low && !pin_s2_q[1] && pin_s3_q[1];
  assign si_s = pin_s2_q[2];

  // ----------------------------------------------------------------
  // command shifter
  // ----------------------------------------------------------------
  logic [15:0] cnt_q;
  logic [31:0] sh_q;
  logic [7:0] op_q, data_q;
  logic [23:0] addr_q;

  // count saturates so a very long read cannot alias a short frame
  always_ff @(posedge clk) begin
    if (rst || !cs_low) begin
      cnt_q <= 16'h0000;
    end else if (sck_rise && cnt_q != 16'hFFFF) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sh_q <= 32'h0000_0000;
      op_q <= 8'h00;
      addr_q <= 24'h00_0000;
      data_q <= 8'h00;
    end else if (sck_rise) begin
      sh_q <= {sh_q[30:0], si_s};
      if (cnt_q == sfepoc_pkg::BITS_OPCODE - 16'h0001) begin
        op_q <= {sh_q[6:0], si_s};
      end
      if (cnt_q == sfepoc_pkg::BITS_ADDR - 16'h0001) begin
        addr_q <= {sh_q[22:0], si_s};
      end
      if (cnt_q == sfepoc_pkg::BITS_OTP_WRITE - 16'h0001) begin
        data_q <= {sh_q[6:0], si_s};
      end
    end
  end

  // ----------------------------------------------------------------
  // command decode at cs rise
  // ----------------------------------------------------------------
  sfepoc_pkg::sfepoc_state_t st_q;
  logic [31:0] tmr_q;
  logic [63:0] lock_q;
  logic [6:0] sector;
  logic sec_prot, idle, otp_ok, locked;
  logic sec_erase_ok, all_erase_ok, pp_ok, sleep_ok, wake_hit, clear_ok;
  logic latch_set_ok;

  assign idle = (st_q == sfepoc_pkg::ST_IDLE);
  assign sector = addr_q[22:16];
  // protected sectors grow from the top of the array
  assign sec_prot = (block_protect_field == 3'h7) ||
    ((block_protect_field != 3'h0) &&
     ({1'b0, sector} >= 8'h80 - (8'h01 << block_protect_field)));
  assign otp_ok = (addr_q[23:10] == 14'h0000) &&
    (int'(addr_q[9:0]) < sfepoc_pkg::OTP_DEPTH);
  assign locked = !lock_q[addr_q[9:4]];

  assign sec_erase_ok = idle && (op_q == sfepoc_pkg::OP_SECTOR_ERASE) &&
    (cnt_q == sfepoc_pkg::BITS_ADDR) && write_enable_latch_q &&
    !sec_prot;
  assign all_erase_ok = idle && (op_q == sfepoc_pkg::OP_ARRAY_ERASE) &&
    (cnt_q == sfepoc_pkg::BITS_OPCODE) && write_enable_latch_q &&
    (block_protect_field == 3'h0);
  assign pp_ok = idle && (op_q == sfepoc_pkg::OP_OTP_WRITE) &&
    (cnt_q == sfepoc_pkg::BITS_OTP_WRITE) && write_enable_latch_q &&
    otp_ok && !locked;
  assign sleep_ok = idle && (op_q == sfepoc_pkg::OP_DEEP_SLEEP) &&
    (cnt_q == sfepoc_pkg::BITS_OPCODE);
  assign wake_hit = (op_q == sfepoc_pkg::OP_WAKE_SIG) &&
    (cnt_q >= sfepoc_pkg::BITS_OPCODE);
  assign clear_ok = idle && (op_q == sfepoc_pkg::OP_CLEAR_FAIL) &&
    (cnt_q == sfepoc_pkg::BITS_OPCODE);
  assign latch_set_ok = idle && (op_q == sfepoc_pkg::OP_WRITE_ENABLE) &&
    (cnt_q == sfepoc_pkg::BITS_OPCODE);

  // ----------------------------------------------------------------
  // operation and power state
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= sfepoc_pkg::ST_IDLE;
      tmr_q <= 32'h0000_0000;
      write_in_progress_bit_q <= 1'b0;
      deep_sleep_q <= 1'b0;
      erase_go_q <= 1'b0;
      erase_all_q <= 1'b0;
      erase_sector_q <= 7'h00;
    end else begin
      erase_go_q <= 1'b0;
      unique case (st_q)
        sfepoc_pkg::ST_IDLE: begin
          if (cs_rise && sec_erase_ok) begin
            st_q <= sfepoc_pkg::ST_BUSY;
            tmr_q <= 32'(SECTOR_ERASE_CYC - 1);
            write_in_progress_bit_q <= 1'b1;
            erase_go_q <= 1'b1;
            erase_all_q <= 1'b0;
            erase_sector_q <= sector;
          end else if (cs_rise && all_erase_ok) begin
            st_q <= sfepoc_pkg::ST_BUSY;
            tmr_q <= 32'(ARRAY_ERASE_CYC - 1);
            write_in_progress_bit_q <= 1'b1;
            erase_go_q <= 1'b1;
            erase_all_q <= 1'b1;
          end else if (cs_rise && pp_ok) begin
            st_q <= sfepoc_pkg::ST_BUSY;
            tmr_q <= 32'(OTP_WRITE_CYC - 1);
            write_in_progress_bit_q <= 1'b1;
          end else if (cs_rise && sleep_ok) begin
            st_q <= sfepoc_pkg::ST_ENTER;
            tmr_q <= 32'(sfepoc_pkg::SLEEP_ENTRY_CYC - 1);
          end
        end
        sfepoc_pkg::ST_BUSY: begin
          if (tmr_q == 32'h0000_0000) begin
            st_q <= sfepoc_pkg::ST_IDLE;
            write_in_progress_bit_q <= 1'b0;
          end else begin
            tmr_q <= tmr_q - 32'h0000_0001;
          end
        end
        sfepoc_pkg::ST_ENTER: begin
          if (tmr_q == 32'h0000_0000) begin
            st_q <= sfepoc_pkg::ST_DEEP;
            deep_sleep_q <= 1'b1;
          end else begin
            tmr_q <= tmr_q - 32'h0000_0001;
          end
        end
        sfepoc_pkg::ST_DEEP: begin
          if (cs_rise && wake_hit) begin
            st_q <= sfepoc_pkg::ST_WAKE;
            tmr_q <= 32'(sfepoc_pkg::WAKE_CYC - 1);
          end
        end
        sfepoc_pkg::ST_WAKE: begin
          if (tmr_q == 32'h0000_0000) begin
            st_q <= sfepoc_pkg::ST_IDLE;
            deep_sleep_q <= 1'b0;
          end else begin
            tmr_q <= tmr_q - 32'h0000_0001;
          end
        end
        default: begin
          st_q <= sfepoc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status bits
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      write_enable_latch_q <= 1'b0;
    end else if (cs_rise && (sec_erase_ok || all_erase_ok || pp_ok)) begin
      write_enable_latch_q <= 1'b0;
    end else if (cs_rise && latch_set_ok) begin
      write_enable_latch_q <= 1'b1;
    end
  end

  // a fail event in the clearing cycle survives the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      erase_fail_flag_q <= 1'b0;
      program_fail_flag_q <= 1'b0;
    end else begin
      if (erase_fail_set) begin
        erase_fail_flag_q <= 1'b1;
      end else if (cs_rise && clear_ok) begin
        erase_fail_flag_q <= 1'b0;
      end
      if (program_fail_set) begin
        program_fail_flag_q <= 1'b1;
      end else if (cs_rise && clear_ok) begin
        program_fail_flag_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // otp space: read-modify-write so programming only clears bits
  // ----------------------------------------------------------------
  logic prog_p1_q, prog_p2_q, rd_on, sig_on, rd_in;
  logic [15:0] rd_full;
  logic [9:0] mem_rd_addr;
  logic [7:0] mem_rd_data, prog_byte;

  always_ff @(posedge clk) begin
    if (rst) begin
      otp_space_q <= 1'b0;
    end else if (sck_rise && cnt_q == sfepoc_pkg::BITS_OPCODE - 16'h0001 &&
                 idle && ({sh_q[6:0], si_s} == sfepoc_pkg::OP_OTP_WRITE ||
                 {sh_q[6:0], si_s} == sfepoc_pkg::OP_OTP_READ)) begin
      otp_space_q <= 1'b1;
    end else if (cs_rise && !pp_ok) begin
      otp_space_q <= 1'b0;
    end else if (prog_p2_q) begin
      otp_space_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prog_p1_q <= 1'b0;
      prog_p2_q <= 1'b0;
    end else begin
      prog_p1_q <= cs_rise && pp_ok;
      prog_p2_q <= prog_p1_q;
    end
  end

  assign prog_byte = mem_rd_data & data_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      lock_q <= '1;
    end else if (prog_p2_q) begin
      for (int i = 0; i < sfepoc_pkg::OTP_LOCK_BYTES; i++) begin
        if (int'(addr_q[9:0]) == sfepoc_pkg::OTP_LOCK_BASE + i) begin
          lock_q[i*8 +: 8] <= lock_q[i*8 +: 8] & data_q;
        end
      end
    end
  end

  assign rd_on = otp_space_q && (op_q == sfepoc_pkg::OP_OTP_READ) &&
    (cnt_q >= sfepoc_pkg::BITS_OTP_DATA);
  assign rd_full = {6'h00, addr_q[9:0]} +
    ((cnt_q - sfepoc_pkg::BITS_OTP_DATA) >> 3);
  // past the top the address is pushed out of range, no wrap
  assign rd_in = (addr_q[23:10] == 14'h0000) && (rd_full < 16'h0400);
  assign mem_rd_addr = (op_q == sfepoc_pkg::OP_OTP_WRITE) ? addr_q[9:0] :
    (rd_in ? rd_full[9:0] : 10'h3FF);

  sfepoc_otp_mem #(
    .DEPTH(sfepoc_pkg::OTP_DEPTH),
    .AW(10)
  ) u_otp (
    .clk(clk),
    .rst(rst),
    .rd_addr(mem_rd_addr),
    .rd_data_q(mem_rd_data),
    .wr_en(prog_p2_q),
    .wr_addr(addr_q[9:0]),
    .wr_data(prog_byte)
  );

  // ----------------------------------------------------------------
  // serial output
  // ----------------------------------------------------------------
  assign sig_on = (op_q == sfepoc_pkg::OP_WAKE_SIG) &&
    (cnt_q >= sfepoc_pkg::BITS_SIG_START) &&
    (st_q != sfepoc_pkg::ST_BUSY);

  always_ff @(posedge clk) begin
    if (rst || !cs_low) begin
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end else if (sck_fall && sig_on) begin
      so_q <= SIGNATURE[3'h7 - cnt_q[2:0]];
      so_oe_q <= 1'b1;
    end else if (sck_fall && rd_on) begin
      so_q <= mem_rd_data[3'h7 - cnt_q[2:0]];
      so_oe_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_sec_erase_start;
    cs_rise && sec_erase_ok;
  endsequence

  sequence s_erase_running;
    erase_go_q && write_in_progress_bit_q && !write_enable_latch_q;
  endsequence

  property p_sec_erase_start;
    @(posedge clk) disable iff (rst)
    s_sec_erase_start |=> s_erase_running ##0
      (erase_sector_q == $past(sector));
  endproperty
  a_sec_erase_start: assert property (p_sec_erase_start)
    else $error("sector erase did not start");

  property p_sec_erase_protect;
    @(posedge clk) disable iff (rst)
    cs_rise && idle && sec_prot |=> !erase_go_q;
  endproperty
  a_sec_erase_protect: assert property (p_sec_erase_protect)
    else $error("erase of protected sector started");

  property p_all_erase_prot;
    @(posedge clk) disable iff (rst)
    erase_go_q && erase_all_q |-> $past(block_protect_field) == 3'h0;
  endproperty
  a_all_erase_prot: assert property (p_all_erase_prot)
    else $error("array erase with protect bits set");

  property p_bad_count;
    @(posedge clk) disable iff (rst)
    cs_rise && (op_q == sfepoc_pkg::OP_SECTOR_ERASE) &&
    (cnt_q != sfepoc_pkg::BITS_ADDR) |=> !erase_go_q;
  endproperty
  a_bad_count: assert property (p_bad_count)
    else $error("erase started on wrong bit count");

  property p_busy_no_sleep;
    @(posedge clk) disable iff (rst)
    (st_q == sfepoc_pkg::ST_BUSY) && cs_rise && (tmr_q > 32'h1) |=>
      (st_q == sfepoc_pkg::ST_BUSY) [*2];
  endproperty
  a_busy_no_sleep: assert property (p_busy_no_sleep)
    else $error("busy operation disturbed");

  property p_reset_standby;
    @(posedge clk) rst |=> !deep_sleep_q && idle;
  endproperty
  a_reset_standby: assert property (p_reset_standby)
    else $error("not in standby after reset");

  property p_deep_discard;
    @(posedge clk) disable iff (rst)
    (st_q == sfepoc_pkg::ST_DEEP) && cs_rise && !wake_hit |=>
      (st_q == sfepoc_pkg::ST_DEEP) && $stable(write_enable_latch_q);
  endproperty
  a_deep_discard: assert property (p_deep_discard)
    else $error("command acted in deep sleep");

  property p_wake;
    @(posedge clk) disable iff (rst)
    (st_q == sfepoc_pkg::ST_DEEP) && cs_rise && wake_hit |=>
      $stable(write_enable_latch_q) ##[1:400] !deep_sleep_q;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake did not return to standby");

  property p_clear_flags;
    @(posedge clk) disable iff (rst)
    cs_rise && clear_ok && !erase_fail_set && !program_fail_set |=>
      !erase_fail_flag_q && !program_fail_flag_q &&
      $stable(write_enable_latch_q);
  endproperty
  a_clear_flags: assert property (p_clear_flags)
    else $error("fail flags not cleared");

  property p_signature;
    @(posedge clk) disable iff (rst)
    sck_fall && sig_on |=> so_oe_q &&
      (so_q == SIGNATURE[7 - $past(cnt_q[2:0])]);
  endproperty
  a_signature: assert property (p_signature)
    else $error("wrong signature bit");

  // a frame sent while busy must leave the output line untouched
  property p_busy_quiet;
    @(posedge clk) disable iff (rst)
    (st_q == sfepoc_pkg::ST_BUSY) && sck_fall |=>
      $stable(so_oe_q) && $stable(so_q);
  endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("output driven while busy");
endmodule : sfepoc_top

// >>> test/sfepoc_host_model.sv
module sfepoc_host_model (
  input wire logic clk,
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so_q,
  input wire logic so_oe_q
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end

  // ----------------------------------------------------------------
  // one frame of n bits, sck parked low outside frames
  // ----------------------------------------------------------------
  task automatic xfer(input logic [63:0] b, input int n,
                      output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      repeat (2) @(posedge clk);
      si <= b[63 - i];
      repeat (3) @(posedge clk);
      // so was launched by the previous fall and has settled by now
      rd = {rd[6:0], so_q & so_oe_q};
      sck <= 1'b1;
      repeat (5) @(posedge clk);
      sck <= 1'b0;
    end
    repeat (5) @(posedge clk);
    cs_n <= 1'b1;
    // released line shows the inverse so a stale level is never trusted
    si <= ~si;
    repeat (8) @(posedge clk);
  endtask : xfer
endmodule : sfepoc_host_model

// >>> test/sfepoc_tb_top.sv
module sfepoc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] SIG = 8'h5A; // arbitrary value
  logic clk, rst, cs_n, sck, si, so_q, so_oe_q;
  logic efs, pfs, latch, busy, eff, pff, dsl, otp, go, all;
  logic [2:0] bp;
  logic [6:0] sec;
  logic [7:0] rd, d, e;
  logic [23:0] a;
  int fail_count = 0;
  int num_checks = 0;
  int gos = 0;
  int g0;
  int seed = 32'he7f90b71;

  // short erase times keep the run small
  sfepoc_top #(.SIGNATURE(SIG), .SECTOR_ERASE_CYC(20),
    .ARRAY_ERASE_CYC(2000), .OTP_WRITE_CYC(20)) dut_u (
    .clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
    .so_q(so_q), .so_oe_q(so_oe_q), .block_protect_field(bp),
    .erase_fail_set(efs), .program_fail_set(pfs),
    .write_enable_latch_q(latch), .write_in_progress_bit_q(busy),
    .erase_fail_flag_q(eff), .program_fail_flag_q(pff),
    .deep_sleep_q(dsl), .otp_space_q(otp), .erase_go_q(go),
    .erase_all_q(all), .erase_sector_q(sec));
  sfepoc_host_model host_u (.clk(clk), .cs_n(cs_n), .sck(sck),
    .si(si), .so_q(so_q), .so_oe_q(so_oe_q));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) if (go) gos <= gos + 1;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] s, input logic [7:0] x);
    num_checks++;
    if (s !== x) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic wait_for(input bit sel, input logic v);
    for (int i = 0; i < 5000; i++) begin
      @(posedge clk);
      if ((sel ? dsl : busy) === v) return;
    end
    fail_count++;
    $display("BAD %0t wait timed out", $time);
    wrap_up();
  endtask : wait_for

  task automatic tx(input logic [63:0] b, input int n);
    host_u.xfer(b, n, rd);
  endtask : tx

  task automatic tx8(input logic [7:0] op);
    tx({op, 56'h0}, 8);
  endtask : tx8

  // top 2^bp of the 128 sectors are protected, none when bp is 0
  function automatic logic prot(input logic [2:0] p, input logic [6:0] s);
    if (p == 3'h0) return 1'b0;
    if (p == 3'h7) return 1'b1;
    return {1'b0, s} >= (8'h80 - (8'h01 << p));
  endfunction : prot

  task automatic ers(input logic [31:0] f, input int n, input bit we,
                     input logic ex);
    if (we) tx8(sfepoc_pkg::OP_WRITE_ENABLE);
    g0 = gos;
    tx({f, 32'h0}, n);
    chk(8'(gos - g0), {7'h0, ex});
    if (ex) begin
      chk({5'h0, all, busy, latch}, {5'h0, n == 8, 2'b10});
      if (n == 32) chk({1'b0, sec}, {1'b0, f[22:16]});
      if (n == 32) wait_for(1'b0, 1'b0);
    end
  endtask : ers

  task automatic otp_wr(input logic [23:0] ad, input logic [7:0] dt,
                        input int n);
    tx8(sfepoc_pkg::OP_WRITE_ENABLE);
    tx({sfepoc_pkg::OP_OTP_WRITE, ad, dt, 24'h0}, n);
    wait_for(1'b0, 1'b0);
  endtask : otp_wr

  task automatic otp_rd(input logic [23:0] ad, input logic [7:0] x);
    host_u.xfer({sfepoc_pkg::OP_OTP_READ, ad, 32'h0}, 48, rd);
    chk(rd, x);
    chk({7'h0, otp}, 8'h00);
  endtask : otp_rd

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst <= 1'b1;
    bp <= 3'h0;
    efs <= 1'b0;
    pfs <= 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk({4'h0, latch, busy, dsl, otp}, 8'h00);
    $display("test reset done");
    tx8(sfepoc_pkg::OP_WRITE_ENABLE);
    efs <= 1'b1;
    pfs <= 1'b1;
    @(posedge clk);
    efs <= 1'b0;
    pfs <= 1'b0;
    @(posedge clk);
    chk({5'h0, eff, pff, latch}, 8'h07);
    tx8(sfepoc_pkg::OP_CLEAR_FAIL);
    chk({5'h0, eff, pff, latch}, 8'h01);
    $display("test clear flags done");
    a = 24'($random(seed));
    ers({sfepoc_pkg::OP_SECTOR_ERASE, a}, 32, 1, 1'b1);
    ers({sfepoc_pkg::OP_SECTOR_ERASE, a}, 32, 0, 1'b0);
    ers({sfepoc_pkg::OP_SECTOR_ERASE, a}, 31, 1, 1'b0);
    ers({sfepoc_pkg::OP_SECTOR_ERASE, a}, 33, 1, 1'b0);
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 24'h7F_0000 : (i == 1) ? 24'h7D_FFFF : 24'($random(seed));
      bp <= (i < 2) ? 3'h1 : 3'($random(seed));
      @(posedge clk);
      ers({sfepoc_pkg::OP_SECTOR_ERASE, a}, 32, 1, !prot(bp, a[22:16]));
    end
    $display("test sector erase done");
    bp <= 3'h4;
    @(posedge clk);
    ers({sfepoc_pkg::OP_ARRAY_ERASE, 24'h0}, 8, 1, 1'b0);
    bp <= 3'h0;
    @(posedge clk);
    ers({sfepoc_pkg::OP_ARRAY_ERASE, 24'h0}, 8, 1, 1'b1);
    tx8(sfepoc_pkg::OP_DEEP_SLEEP);
    repeat (400) @(posedge clk);
    chk({6'h0, dsl, busy}, 8'h01);
    // signature request during the erase must stay unanswered
    host_u.xfer({sfepoc_pkg::OP_WAKE_SIG, 56'h0}, 40, rd);
    chk(rd, 8'h00);
    wait_for(1'b0, 1'b0);
    $display("test array erase done");
    tx({sfepoc_pkg::OP_DEEP_SLEEP, 56'h0}, 9);
    repeat (400) @(posedge clk);
    chk({7'h0, dsl}, 8'h00);
    tx8(sfepoc_pkg::OP_WRITE_ENABLE);
    tx8(sfepoc_pkg::OP_DEEP_SLEEP);
    wait_for(1'b1, 1'b1);
    ers({sfepoc_pkg::OP_SECTOR_ERASE, 24'h0}, 32, 0, 1'b0);
    host_u.xfer({sfepoc_pkg::OP_WAKE_SIG, 56'h0}, 40, rd);
    chk(rd, SIG);
    wait_for(1'b1, 1'b0);
    chk({7'h0, latch}, 8'h01);
    host_u.xfer({sfepoc_pkg::OP_WAKE_SIG, 56'h0}, 48, rd);
    chk(rd, SIG);
    $display("test sleep and wake done");
    a = {14'h0, 6'h10, 4'($random(seed))};
    d = 8'($random(seed));
    e = 8'($random(seed));
    otp_wr(a, d, 40);
    otp_rd(a, d);
    otp_wr(a, e, 40);
    otp_rd(a, d & e);
    otp_wr(a, 8'h00, 48);
    otp_rd(a, d & e);
    // region 16 is guarded by bit 0 of the third lock byte
    otp_wr(24'h00_0012, 8'hFE, 40);
    otp_wr(a, 8'h00, 40);
    otp_rd(a, d & e);
    otp_rd(24'h00_0214, 8'hFF);
    $display("test otp done");
    wrap_up();
  end
endmodule : sfepoc_tb_top
